// >>> design/irq_context_store.sv
// One-stage context store for interrupt entry, registered read port
`timescale 1ns/1ps
module irq_context_store #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             save_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] data_o
);
  logic [WIDTH-1:0] store;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      store <= '0;
    else if (save_i)
      store <= data_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      data_o <= '0;
    else
      data_o <= store;
  end
endmodule

// >>> design/irq_unit_pkg.sv
// Constants and carrier types for the vectored interrupt unit
package irq_unit_pkg;
  localparam int PC_W          = 14;
  localparam int PAGE_WORDS    = 128;
  localparam int VEC_PAGE      = 1;
  localparam int NUM_SRC       = 4;
  localparam int SRC_EXT       = 0;
  localparam int SRC_TA        = 1;
  localparam int SRC_TB        = 2;
  localparam int SRC_TC        = 3;
  localparam logic [6:0] OFF_EXT = 7'h00;
  localparam logic [6:0] OFF_TA  = 7'h04;
  localparam logic [6:0] OFF_TB  = 7'h06;
  localparam logic [6:0] OFF_TC  = 7'h08;
  localparam int LAT_SHORT     = 2;
  localparam int LAT_LONG      = 3;
  localparam int CTRL_A_EXT    = 0;
  localparam int CTRL_A_TA     = 2;
  localparam int CTRL_A_TB     = 3;
  localparam int CTRL_B_TC     = 0;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] NO_SRC     = 4'h0;

  typedef struct packed {
    logic       enable_irq_instr;
    logic       disable_irq_instr;
    logic       instr_done;
    logic       multi_cycle;
    logic       write_ctrl_a;
    logic       write_ctrl_b;
    logic [3:0] ctrl_data;
    logic [3:0] skip_test;
  } seq_cmd_t;

  typedef struct packed {
    logic            valid;
    logic [3:0]      source;
    logic [PC_W-1:0] vector;
  } entry_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_ENTER = 3'b100
  } entry_state_t;
endpackage

// >>> design/vectored_interrupt_unit.sv
// Vectored interrupt unit: request flags, enables, priority and vector entry
// What this block does
// - Take interrupt only with global enable, source enable and request all set.
// - Enable instruction sets global enable; disable instruction clears it.
// - Taking any interrupt clears global enable until enable instruction again.
// - Each enable bit selects interrupt use or skip-test use of its flag.
// - Source activation sets its request flag.
// - Flag clears when its interrupt taken or its skip succeeds.
// - Flags set even when interrupts are disabled.
// - Flags hold until cleared; pending flag interrupts once enabled.
// - Fixed priority: external, timer a, timer b, timer c.
// - Vectors at page 1 words 0, 4, 6, 8.
// - Entry loads program counter with serviced source vector.
// - Vector address is page times 128 plus offset.
// - Enable bit 1 blocks skip; enable bit 0 allows skip.
// - Entry 2 cycles after conditions, 3 during multi-cycle instruction.
// - Entry pushes return address and saves context into one-stage store.
// - Enable instruction effective only after one more instruction.
`timescale 1ns/1ps
module vectored_interrupt_unit #(
  parameter int CTX_W = 16
) (
  input  wire logic                          REF_CLK_I,
  input  wire logic                          RESET_I,
  input  wire logic                          EXT_IRQ_PIN_I,
  input  wire logic                          EXT_RISING_SEL_I,
  input  wire logic [2:0]                    TIMER_UNDERFLOW_I,
  input  wire irq_unit_pkg::seq_cmd_t        SEQ_CMD_I,
  input  wire logic [irq_unit_pkg::PC_W-1:0] RETURN_ADDR_I,
  input  wire logic [CTX_W-1:0]              CONTEXT_I,
  output irq_unit_pkg::entry_t               ENTRY_O,
  output logic                               RETURN_PUSH_O,
  output logic [irq_unit_pkg::PC_W-1:0]      RETURN_ADDR_O,
  output logic [CTX_W-1:0]                   CONTEXT_O,
  output logic                               SKIP_RESULT_O,
  output logic                               GLOBAL_IRQ_ENABLE_FLAG_O,
  output logic [3:0]                         REQUEST_FLAGS_O,
  output logic [3:0]                         IRQ_CONTROL_REG_A_O,
  output logic [3:0]                         IRQ_CONTROL_REG_B_O
);
  logic [1:0] ext_sync;
  logic       ext_prev;
  logic       ext_irq_request_flag;
  logic       timer_a_request_flag;
  logic       timer_b_request_flag;
  logic       timer_c_request_flag;
  logic       global_irq_enable_flag;
  logic       enable_pending;
  logic [3:0] irq_control_reg_a;
  logic [3:0] irq_control_reg_b;
  logic [3:0] request;
  logic [3:0] enables;
  logic [3:0] eligible;
  logic [3:0] winner;
  logic [3:0] served;
  logic [3:0] skip_clear;
  logic [3:0] set_event;
  logic       ext_edge;
  logic [1:0] wait_cnt;
  logic [1:0] next_wait_cnt;
  logic       take;
  irq_unit_pkg::entry_state_t state;
  irq_unit_pkg::entry_state_t next_state;

  function automatic logic [3:0] pick_highest(input logic [3:0] req);
    pick_highest = irq_unit_pkg::NO_SRC;
    for (int i = irq_unit_pkg::NUM_SRC - 1; i >= 0; i--)
      if (req[i])
        pick_highest = 4'(1 << i);
  endfunction

  function automatic logic [irq_unit_pkg::PC_W-1:0] vector_of(input logic [3:0] src);
    logic [6:0] off;
    off = irq_unit_pkg::OFF_EXT;
    case (1'b1)
      src[irq_unit_pkg::SRC_TA]: off = irq_unit_pkg::OFF_TA;
      src[irq_unit_pkg::SRC_TB]: off = irq_unit_pkg::OFF_TB;
      src[irq_unit_pkg::SRC_TC]: off = irq_unit_pkg::OFF_TC;
      default:                   off = irq_unit_pkg::OFF_EXT;
    endcase
    vector_of = irq_unit_pkg::PC_W'(irq_unit_pkg::VEC_PAGE * irq_unit_pkg::PAGE_WORDS)
              + irq_unit_pkg::PC_W'(off);
  endfunction

  // Pin crosses into the machine clock through two flops
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      ext_sync <= 2'h0;
    else
      ext_sync <= {ext_sync[0], EXT_IRQ_PIN_I};
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      ext_prev <= 1'b0;
    else
      ext_prev <= ext_sync[1];
  end

  assign ext_edge  = EXT_RISING_SEL_I ? (ext_sync[1] & ~ext_prev) : (~ext_sync[1] & ext_prev);
  assign set_event = {TIMER_UNDERFLOW_I, ext_edge};
  assign request   = {timer_c_request_flag, timer_b_request_flag, timer_a_request_flag, ext_irq_request_flag};
  assign enables   = {irq_control_reg_b[irq_unit_pkg::CTRL_B_TC], irq_control_reg_a[irq_unit_pkg::CTRL_A_TB],
                      irq_control_reg_a[irq_unit_pkg::CTRL_A_TA], irq_control_reg_a[irq_unit_pkg::CTRL_A_EXT]};
  assign eligible  = request & enables & {4{global_irq_enable_flag}};
  assign winner    = pick_highest(eligible);
  // Skip only tests flags whose enable bit is 0
  assign skip_clear = SEQ_CMD_I.skip_test & request & ~enables;
  assign take       = (state == irq_unit_pkg::ST_ENTER);
  assign served     = take ? ENTRY_O.source : irq_unit_pkg::NO_SRC;

  // Set beats clear so a same-cycle event is never lost
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      ext_irq_request_flag <= 1'b0;
      timer_a_request_flag <= 1'b0;
      timer_b_request_flag <= 1'b0;
      timer_c_request_flag <= 1'b0;
    end
    else
    begin
      ext_irq_request_flag <= set_event[irq_unit_pkg::SRC_EXT] |
        (ext_irq_request_flag & ~served[irq_unit_pkg::SRC_EXT] & ~skip_clear[irq_unit_pkg::SRC_EXT]);
      timer_a_request_flag <= set_event[irq_unit_pkg::SRC_TA] |
        (timer_a_request_flag & ~served[irq_unit_pkg::SRC_TA] & ~skip_clear[irq_unit_pkg::SRC_TA]);
      timer_b_request_flag <= set_event[irq_unit_pkg::SRC_TB] |
        (timer_b_request_flag & ~served[irq_unit_pkg::SRC_TB] & ~skip_clear[irq_unit_pkg::SRC_TB]);
      timer_c_request_flag <= set_event[irq_unit_pkg::SRC_TC] |
        (timer_c_request_flag & ~served[irq_unit_pkg::SRC_TC] & ~skip_clear[irq_unit_pkg::SRC_TC]);
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      SKIP_RESULT_O <= 1'b0;
    else
      SKIP_RESULT_O <= |skip_clear;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      irq_control_reg_a <= irq_unit_pkg::CTRL_RESET;
      irq_control_reg_b <= irq_unit_pkg::CTRL_RESET;
    end
    else
    begin
      if (SEQ_CMD_I.write_ctrl_a)
        irq_control_reg_a <= SEQ_CMD_I.ctrl_data;
      if (SEQ_CMD_I.write_ctrl_b)
        irq_control_reg_b <= SEQ_CMD_I.ctrl_data;
    end
  end

  // Enable waits for one more finished instruction
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      enable_pending <= 1'b0;
    else if (SEQ_CMD_I.disable_irq_instr || take)
      enable_pending <= 1'b0;
    else if (SEQ_CMD_I.enable_irq_instr)
      enable_pending <= 1'b1;
    else if (SEQ_CMD_I.instr_done)
      enable_pending <= 1'b0;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      global_irq_enable_flag <= 1'b0;
    else if (take || SEQ_CMD_I.disable_irq_instr)
      global_irq_enable_flag <= 1'b0;
    else if (enable_pending && SEQ_CMD_I.instr_done && !SEQ_CMD_I.enable_irq_instr)
      global_irq_enable_flag <= 1'b1;
  end

  // Entry sequencing: latency counted from the first cycle conditions hold
  always_comb
  begin
    next_state    = state;
    next_wait_cnt = wait_cnt;
    case (state)
      irq_unit_pkg::ST_IDLE:
      begin
        if (|eligible)
        begin
          next_state    = irq_unit_pkg::ST_WAIT;
          next_wait_cnt = SEQ_CMD_I.multi_cycle ? 2'(irq_unit_pkg::LAT_LONG - 2)
                                                : 2'(irq_unit_pkg::LAT_SHORT - 2);
        end
      end
      irq_unit_pkg::ST_WAIT:
      begin
        if (wait_cnt == 2'h0)
          next_state = irq_unit_pkg::ST_ENTER;
        else
          next_wait_cnt = wait_cnt - 2'h1;
      end
      irq_unit_pkg::ST_ENTER:
        next_state = irq_unit_pkg::ST_IDLE;
      default:
        next_state = irq_unit_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      state    <= irq_unit_pkg::ST_IDLE;
      wait_cnt <= 2'h0;
    end
    else
    begin
      state    <= next_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  // Winner is frozen when the wait starts; later flags wait their turn
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      ENTRY_O <= '0;
    else
    begin
      ENTRY_O.valid <= (next_state == irq_unit_pkg::ST_ENTER);
      if (state == irq_unit_pkg::ST_IDLE && |eligible)
      begin
        ENTRY_O.source <= winner;
        ENTRY_O.vector <= vector_of(winner);
      end
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      RETURN_PUSH_O <= 1'b0;
      RETURN_ADDR_O <= '0;
    end
    else
    begin
      RETURN_PUSH_O <= (next_state == irq_unit_pkg::ST_ENTER);
      if (next_state == irq_unit_pkg::ST_ENTER)
        RETURN_ADDR_O <= RETURN_ADDR_I;
    end
  end

  irq_context_store #(
    .WIDTH (CTX_W)
  ) u_ctx (
    .clk_i  (REF_CLK_I),
    .rst_i  (RESET_I),
    .save_i (next_state == irq_unit_pkg::ST_ENTER),
    .data_i (CONTEXT_I),
    .data_o (CONTEXT_O)
  );

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      GLOBAL_IRQ_ENABLE_FLAG_O <= 1'b0;
      REQUEST_FLAGS_O          <= 4'h0;
      IRQ_CONTROL_REG_A_O      <= irq_unit_pkg::CTRL_RESET;
      IRQ_CONTROL_REG_B_O      <= irq_unit_pkg::CTRL_RESET;
    end
    else
    begin
      GLOBAL_IRQ_ENABLE_FLAG_O <= global_irq_enable_flag;
      REQUEST_FLAGS_O          <= request;
      IRQ_CONTROL_REG_A_O      <= irq_control_reg_a;
      IRQ_CONTROL_REG_B_O      <= irq_control_reg_b;
    end
  end

  sequence cond_seq;
    (state == irq_unit_pkg::ST_IDLE) && (|eligible) && !SEQ_CMD_I.multi_cycle;
  endsequence

  latency_short_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    cond_seq |-> ##2 ENTRY_O.valid) else $error("entry not two cycles after conditions");
  entry_clears_ie_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    take |=> !global_irq_enable_flag) else $error("global enable not cleared on entry");
  entry_needs_ie_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    (state == irq_unit_pkg::ST_IDLE && next_state == irq_unit_pkg::ST_WAIT) |-> global_irq_enable_flag)
    else $error("entry started without global enable");
  disable_instr_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    SEQ_CMD_I.disable_irq_instr |=> !global_irq_enable_flag) else $error("disable instruction ignored");
  ei_delay_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    (SEQ_CMD_I.enable_irq_instr && !global_irq_enable_flag) |=> !global_irq_enable_flag)
    else $error("enable took effect too early");
  flag_set_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    TIMER_UNDERFLOW_I[0] |=> timer_a_request_flag) else $error("timer flag not set");
  flag_hold_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    (ext_irq_request_flag && !served[0] && !skip_clear[0]) |=> ext_irq_request_flag)
    else $error("flag dropped without clear");
  vector_value_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    (ENTRY_O.valid && ENTRY_O.source[irq_unit_pkg::SRC_TC]) |-> ENTRY_O.vector == 14'h0088)
    else $error("timer c vector wrong");
  // A same-cycle skip of the external flag is a legal clear, so it is left out here
  only_served_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    (take && !ENTRY_O.source[irq_unit_pkg::SRC_EXT] && ext_irq_request_flag && !skip_clear[irq_unit_pkg::SRC_EXT])
    |=> ext_irq_request_flag)
    else $error("unserved flag cleared");
  skip_blocked_a: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    (SEQ_CMD_I.skip_test[irq_unit_pkg::SRC_EXT] && irq_control_reg_a[irq_unit_pkg::CTRL_A_EXT])
    |=> !SKIP_RESULT_O || $past(|skip_clear[3:1]))
    else $error("skip effective while enabled");
endmodule

// >>> verification/irq_seq_model.sv
// Sequencer and event source model on the far side of the interrupt unit
`timescale 1ns/1ps
module irq_seq_model (
  input  wire logic              clk_i,
  input  wire logic              multi_i,
  output irq_unit_pkg::seq_cmd_t cmd_o,
  output logic [2:0]             timer_o,
  output logic                   ext_pin_o
);
  irq_unit_pkg::seq_cmd_t pulse;

  // Multi-cycle is a level from the bench, the rest are task pulses
  always_comb
  begin
    cmd_o             = pulse;
    cmd_o.multi_cycle = multi_i;
  end

  initial
  begin
    pulse     = '0;
    timer_o   = 3'h0;
    ext_pin_o = 1'b0;
  end

  // Called just after a falling edge; the idle cycle keeps calls from colliding
  task automatic issue(input irq_unit_pkg::seq_cmd_t c);
    pulse <= c;
    @(negedge clk_i);
    pulse <= '0;
    @(negedge clk_i);
  endtask

  task automatic underflow(input logic [2:0] m);
    timer_o <= m;
    @(negedge clk_i);
    timer_o <= 3'h0;
    @(negedge clk_i);
  endtask

  // Pin stays high afterwards, so only one rising edge is seen
  task automatic ext_rise();
    ext_pin_o <= 1'b1;
    @(negedge clk_i);
  endtask

  task automatic ext_fall();
    ext_pin_o <= 1'b0;
    @(negedge clk_i);
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking testbench for the vectored interrupt unit
`timescale 1ns/1ps
module tb_top;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   sel = 1'b1;
  logic                   mc = 1'b0;
  logic [13:0]            ret_addr = 14'h0000;
  logic [15:0]            ctx = 16'h0000;
  irq_unit_pkg::seq_cmd_t cmd;
  logic [2:0]             tmr;
  logic                   ext_pin;
  irq_unit_pkg::entry_t   entry;
  logic                   push, skip, ie;
  logic [13:0]            ret_o;
  logic [15:0]            ctx_o;
  logic [3:0]             flags, rega, regb;
  logic [17:0]            exp_q[$];
  logic [6:0]             off[4];
  int                     err_count = 0;
  int                     n_compared = 0;
  int                     seed = 19;
  int                     cyc = 0;
  int                     n_skip = 0;
  // Command bits in field order: ei, di, done, multi, write a, write b
  localparam logic [5:0]  OP_EI   = 6'h20;
  localparam logic [5:0]  OP_DI   = 6'h10;
  localparam logic [5:0]  OP_DONE = 6'h08;
  localparam logic [5:0]  OP_WA   = 6'h02;
  localparam logic [5:0]  OP_WB   = 6'h01;
  int                     t_val, start, rnd;
  irq_unit_pkg::seq_cmd_t c;

  vectored_interrupt_unit uut (.REF_CLK_I(clk), .RESET_I(rst), .EXT_IRQ_PIN_I(ext_pin), .EXT_RISING_SEL_I(sel),
    .TIMER_UNDERFLOW_I(tmr), .SEQ_CMD_I(cmd), .RETURN_ADDR_I(ret_addr), .CONTEXT_I(ctx), .ENTRY_O(entry),
    .RETURN_PUSH_O(push), .RETURN_ADDR_O(ret_o), .CONTEXT_O(ctx_o), .SKIP_RESULT_O(skip),
    .GLOBAL_IRQ_ENABLE_FLAG_O(ie), .REQUEST_FLAGS_O(flags), .IRQ_CONTROL_REG_A_O(rega), .IRQ_CONTROL_REG_B_O(regb));

  irq_seq_model u_seq (.clk_i(clk), .multi_i(mc), .cmd_o(cmd), .timer_o(tmr), .ext_pin_o(ext_pin));

  initial
  begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // Skip result stands one cycle only, so pulses are counted where they stand
  always @(negedge clk) if (!rst && skip === 1'b1) n_skip <= n_skip + 1;

  task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Entries are judged where the one-cycle pulse is settled
  always @(negedge clk)
  begin
    if (!rst && entry.valid === 1'b1)
    begin
      t_val = cyc;
      if (exp_q.size() == 0)
        check(18'h0, 18'h1, "unexpected entry");
      else
        check({entry.source, entry.vector}, exp_q.pop_front(), "entry source or vector");
      check(18'(push), 18'h1, "return push");
    end
  end

  task automatic wait_entry();
    int k;
    for (k = 0; k < 40 && exp_q.size() != 0; k++)
      @(negedge clk);
    if (exp_q.size() != 0)
      check(18'h0, 18'h1, "entry missing");
  endtask

  // Multi-cycle bit of op is overridden by the level in the model
  task automatic send(input logic [5:0] op, input logic [3:0] data, input logic [3:0] tst);
    c = irq_unit_pkg::seq_cmd_t'({op, data, tst});
    u_seq.issue(c);
  endtask

  // Enable instruction, then a second completed instruction to arm it
  task automatic enable_ie();
    send(OP_EI | OP_DONE, 4'h0, 4'h0);
    check(18'(ie), 18'h0, "enable took effect early");
    send(OP_DONE, 4'h0, 4'h0);
    repeat (2) @(negedge clk);
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial
  begin
    off = '{irq_unit_pkg::OFF_EXT, irq_unit_pkg::OFF_TA, irq_unit_pkg::OFF_TB, irq_unit_pkg::OFF_TC};
    repeat (6) @(negedge clk);
    rst = 1'b0;
    check(18'({ie, flags, rega, regb, entry.valid}), 18'h0, "reset state");
    rnd = $random(seed);
    send(OP_WA, 4'hD, 4'h0);
    send(OP_WB, {3'(rnd), 1'b1}, 4'h0);
    check(18'({rega, regb}), 18'({4'hD, 3'(rnd), 1'b1}), "control registers");
    u_seq.ext_rise();
    u_seq.underflow(3'h7);
    repeat (6) @(negedge clk);
    check(18'(flags), 18'hF, "flags set while disabled");
    send(6'h00, 4'h0, 4'h8);
    check(18'(n_skip), 18'h0, "skip with enable bit set");
    send(OP_WB, 4'h0, 4'h0);
    send(6'h00, 4'h0, 4'h8);
    check(18'(n_skip), 18'h1, "skip with enable bit clear");
    repeat (2) @(negedge clk);
    check(18'(flags), 18'h7, "flag after skip");
    send(OP_WB, {3'(rnd), 1'b1}, 4'h0);
    u_seq.underflow(3'h4);
    repeat (3) @(negedge clk);
    for (int i = 0; i < 4; i++)
    begin
      rnd = $random(seed);
      ret_addr = 14'(rnd);
      ctx = 16'(rnd >> 14);
      exp_q.push_back({4'(1 << i), 14'(irq_unit_pkg::VEC_PAGE * irq_unit_pkg::PAGE_WORDS) + 14'(off[i])});
      enable_ie();
      wait_entry();
      repeat (3) @(negedge clk);
      check(18'(ret_o), 18'(ret_addr), "saved return address");
      check(18'(ctx_o), 18'(ctx), "saved context");
      check(18'(ie), 18'h0, "enable flag after entry");
      check(18'(flags), 18'(4'(4'hF << (i + 1))), "flags after entry");
    end
    enable_ie();
    check(18'(ie), 18'h1, "enable flag set");
    send(OP_DI, 4'h0, 4'h0);
    repeat (2) @(negedge clk);
    check(18'(ie), 18'h0, "enable flag cleared");
    // Pin is high here, so switching to falling edges makes no false event
    sel = 1'b0;
    u_seq.ext_fall();
    repeat (6) @(negedge clk);
    check(18'(flags), 18'h1, "falling edge flag");
    send(6'h00, 4'h0, 4'h1);
    repeat (2) @(negedge clk);
    check(18'(n_skip), 18'h1, "skip on enabled source");
    check(18'(flags), 18'h1, "flag kept after refused skip");
    // External source masked so its flag stays pending through the timer entries
    send(OP_WA, 4'h4, 4'h0);
    for (int m = 0; m < 2; m++)
    begin
      enable_ie();
      mc = 1'(m);
      exp_q.push_back({4'h2, 14'(irq_unit_pkg::VEC_PAGE * irq_unit_pkg::PAGE_WORDS) + 14'(off[1])});
      start = cyc;
      u_seq.underflow(3'h1);
      wait_entry();
      // One cycle for the flag to set, then the entry latency
      check(18'(t_val - start), 18'((m ? irq_unit_pkg::LAT_LONG : irq_unit_pkg::LAT_SHORT) + 1), "latency");
      mc = 1'b0;
      repeat (3) @(negedge clk);
      check(18'(flags), 18'h1, "unserved flag kept");
    end
    close_out();
  end
endmodule
